// File: bench/instance_select_properties.sv
`timescale 1ns/1ns
// bus answer timing and selection-blind reads
module instance_select_properties #(
   parameter int unsigned NUM_INST = 4,
   parameter logic [3:0] MAX_INDEX = 4'h3
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus as seen at the block
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // events
   input wire logic [NUM_INST-1:0] mon_event_i
);
   // a read taken at this edge
   wire logic rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_arch_fixed: assert property (rd && wb_adr_i == 8'h18 |=> wb_dat_o == 32'h0000_0011)
      else $error("arch id wrong");
   a_narrow_fixed: assert property (rd && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0000_0000)
      else $error("narrowing id wrong");
   a_sel_width: assert property (rd && wb_adr_i[7:3] == 5'h06 |=> wb_dat_o[31:26] == 6'h00)
      else $error("selector upper bits set");
   a_max_index: assert property (rd && wb_adr_i == 8'h00 |=> wb_dat_o[19:16] == MAX_INDEX)
      else $error("max index wrong");
   a_capt_blind: assert property (rd && wb_adr_i == 8'h38 |=> wb_dat_o == 32'h0000_0000)
      else $error("capture event read nonzero");
   a_synd_inst: assert property (rd && wb_adr_i == 8'h2c |=> wb_dat_o[23:18] == 6'h00)
      else $error("syndrome instance too wide");
endmodule
bind instance_select instance_select_properties #(.NUM_INST(NUM_INST), .MAX_INDEX(MAX_INDEX)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_event_i(mon_event_i));

// File: bench/instance_select_test.sv
`timescale 1ns/1ns
module instance_select_test;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wb_ack_o;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, q, wb_dat_o;
   logic [3:0] ev = 4'h0; // event levels per instance
   int bad_count = 0, check_count = 0;
   // error table: partition inst, monitor inst, address, write, syndrome
   logic [2:0] tp [9] = '{2, 3, 1, 0, 0, 0, 3, 2, 2};
   logic [2:0] tm [9] = '{0, 0, 0, 2, 1, 1, 0, 3, 2};
   logic [7:0] ta [9] = '{8'h40, 8'h40, 8'h44, 8'h50, 8'h54, 8'h5c, 8'h18, 8'h00, 8'h38};
   logic tw [9] = '{1, 1, 1, 0, 0, 0, 1, 0, 0};
   logic [31:0] te [9] = '{32'h0802_0000, 32'h0903_0000, 32'h0901_0000, 32'h0a02_0000, 32'h0b01_0000,
      32'h0b01_0000, 32'h0f00_0000, 32'h0000_0000, 32'h0000_0000};
   always #5 clk_i = ~clk_i;
   instance_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_event_i(ev));
   task conclude;
      if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // compare, named by the last register touched
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error register %h expected %h seen %h", adr, exp, seen);
      end
   endtask
   // one classic cycle, held until ack is sampled
   // no cycle count assumed: a wait ends on ack, or at the hang guard
   task acc(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 0; stb <= 0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      acc(a, 0, 0);
      chk(q & m, e);
   endtask
   // both selectors, partition index 0
   task sel(input logic [2:0] p, input logic [2:0] mi);
      acc(8'h30, 1, {5'h00, p, 24'h00_0000});
      acc(8'h34, 1, {5'h00, mi, 24'h00_0000});
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      rdchk(8'h00, 32'h000f_0007, 32'h0003_0007);
      rdchk(8'h04, 32'h0003_0003, 32'h0003_0003);
      rdchk(8'h08, 32'h0000_00ff, 32'h0000_0010);
      sel(7, 0);
      rdchk(8'h30, '1, 32'h0300_0000);
      rdchk(8'h04, '1, 32'h0000_0000);
      sel(1, 0);
      rdchk(8'h08, 32'h0000_00ff, 32'h0000_000a);
      sel(2, 0);
      rdchk(8'h00, 32'h0000_0007, 32'h0000_0000);
      rdchk(8'h10, 32'h0003_0000, 32'h0000_0000);
      rdchk(8'h1c, '1, 32'h0000_1234);
      rdchk(8'h18, '1, instance_select_pkg::ARCH_ID_VALUE);
      rdchk(8'h20, '1, 32'h0000_0000);
      sel(0, 2);
      rdchk(8'h0c, 32'h0000_ffff, 32'h0000_0001);
      // five event cycles on instances 0 and 3, counting enabled on instance 0 only
      sel(0, 0);
      acc(8'h50, 1, 32'h0000_0001);
      ev <= 4'h9;
      repeat (5) @(posedge clk_i);
      ev <= 4'h0;
      repeat (4) @(posedge clk_i);
      rdchk(8'h54, '1, 32'h0000_0005);
      sel(0, 3);
      rdchk(8'h54, '1, 32'h0000_0000);
      // bad selections and a read-only write, syndrome cleared after each
      for (int i = 0; i < 9; i++) begin
         sel(tp[i], tm[i]);
         acc(ta[i], tw[i], 32'h0000_0000);
         rdchk(8'h2c, '1, te[i]);
         acc(8'h2c, 1, 32'h0000_0000);
      end
      conclude;
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      conclude;
   end
endmodule

// File: hdl/instance_select.sv
`timescale 1ns/1ns

// Functional notes
// [R1] downstream polarity reported, valid only with flag
// [R2] internal width and polarity gated by flag
// [R3] bandwidth id fields vary per instance
// [R4] global priority id nonzero only at instance 0
// [R5] fixed registers ignore instance selection
// [R6] monitor selector steers monitor registers
// [R7] component monitors reachable only at instance 0
// [R8] monitor id follows partition selector only
// [R9] selector and capture event ignore selection
// [R10] undefined: over max, unimplemented, or lacking
// [R11] decode instance from implemented bits only
// [R12] undefined instance: all present flags zero
// [R13] id reads never log errors
// [R14] config errors use codes 8 and 9
// [R15] monitor errors use codes 10 and 11
// [R16] syndrome instance copied from matching selector
// [R17] non-instance errors log instance zero
// [R18] software matches selector instances, zero unpartitioned
// [R19] software honours max index and flags
// [R20] main id shows largest instance index
// [R21] common controls use instance zero
// [R22] selector writes apply to next access
// [R23] fixed registers complete for any selection
module instance_select #(
   parameter int unsigned INST_W = 2, // implemented instance bits
   parameter int unsigned NUM_INST = 4, // 2**INST_W
   parameter logic [3:0] MAX_INDEX = 4'h3,
   parameter logic [NUM_INST-1:0] INST_PRESENT = 4'hb, // instance 2 left undefined
   parameter logic [NUM_INST-1:0] HAS_PART = 4'h3,
   parameter logic [NUM_INST-1:0] HAS_BW_MON = 4'h9,
   parameter logic [NUM_INST-1:0] HAS_INT_PRI = 4'h1,
   parameter logic [NUM_INST-1:0] HAS_DS_PRI = 4'h3,
   parameter bit PRI_LOCAL = 1'b0, // priority acts component-wide
   parameter logic [NUM_INST*8-1:0] BW_WIDTH = 32'h0c08_0a10,
   parameter logic [NUM_INST*8-1:0] PRI_WIDTH = 32'h0403_0302,
   parameter logic [31:0] IMPL_ID_VALUE = 32'h0000_1234, // arbitrary value
   parameter logic [31:0] NARROW_ID_VALUE = 32'h0000_0000,
   parameter logic [31:0] SEC_ID_VALUE = 32'h0000_0000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // per-instance monitor events from outside
   input wire logic [NUM_INST-1:0] mon_event_i
);

   // byte-lane merge of write data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // eight-bit per-instance parameter slice
   function automatic logic [7:0] slice8(input logic [NUM_INST*8-1:0] v, input logic [INST_W-1:0] i);
      return v[i*8 +: 8];
   endfunction

   // instance names nothing usable
   function automatic logic undefined(input logic [INST_W-1:0] i);
      return ({{(4-INST_W){1'b0}}, i} > MAX_INDEX) || !INST_PRESENT[i]; // [R10]
   endfunction

   // classify an address
   function automatic instance_select_pkg::reg_kind_type kind_of(input logic [7:0] a);
      case (a)
         instance_select_pkg::OFF_MAIN_ID, instance_select_pkg::OFF_PRI_ID,
         instance_select_pkg::OFF_BW_PART_ID, instance_select_pkg::OFF_BW_MON_ID,
         instance_select_pkg::OFF_MON_SUM_ID, instance_select_pkg::OFF_CACHE_MON_ID: return instance_select_pkg::KIND_ID;
         instance_select_pkg::OFF_ARCH_ID, instance_select_pkg::OFF_IMPL_ID, instance_select_pkg::OFF_NARROW_ID,
         instance_select_pkg::OFF_SEC_ID, instance_select_pkg::OFF_ERR_CTRL, instance_select_pkg::OFF_ERR_SYND,
         instance_select_pkg::OFF_PART_SEL, instance_select_pkg::OFF_MON_SEL,
         instance_select_pkg::OFF_CAPT_EVT: return instance_select_pkg::KIND_FIXED;
         instance_select_pkg::OFF_PART_CTRL, instance_select_pkg::OFF_COMMON_CTRL: return instance_select_pkg::KIND_PART;
         instance_select_pkg::OFF_MON_CFG, instance_select_pkg::OFF_MON_VAL, instance_select_pkg::OFF_MON_CAPT,
         instance_select_pkg::OFF_GLOBAL_MON: return instance_select_pkg::KIND_MON;
         default: return instance_select_pkg::KIND_NONE;
      endcase
   endfunction

   // bus handshake state
   logic ack_q; // one-cycle acknowledge
   logic [31:0] rdata_q; // registered read data
   logic req; // new request this cycle

   // selectors: only implemented instance bits are stored
   logic [instance_select_pkg::SEL_INDEX_W-1:0] part_index_q;
   logic [INST_W-1:0] part_inst_q;
   logic [instance_select_pkg::SEL_INDEX_W-1:0] mon_index_q;
   logic [INST_W-1:0] mon_inst_q;

   // error registers
   logic err_ctrl_q; // stored enable bit, no interrupt here
   logic [3:0] esr_code_q;
   logic [INST_W-1:0] esr_inst_q;
   logic esr_over_q;

   // per-instance and shared control and monitor storage
   logic [31:0] part_ctrl_q [NUM_INST];
   logic [31:0] common_ctrl_q; // shared by all instances
   logic [1:0] mon_cfg_q [NUM_INST];
   logic [31:0] mon_val_q [NUM_INST];
   logic [31:0] mon_capt_q [NUM_INST];
   logic [31:0] global_mon_q; // component-level monitor

   // event synchroniser
   logic [NUM_INST-1:0] evt_meta_q;
   logic [NUM_INST-1:0] evt_q;

   // access decode
   instance_select_pkg::reg_kind_type kind;
   logic [3:0] err_code; // error raised by this access, zero if none
   logic access_ok; // access may touch storage
   logic capture_pulse; // write to capture event register
   logic [31:0] id_word;
   logic [31:0] part_sel_w; // partition selector after byte-lane merge
   logic [31:0] mon_sel_w; // monitor selector after byte-lane merge

   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign kind = kind_of(wb_adr_i);

   // old word carries the stored instance, so a low-lane write keeps it
   assign part_sel_w = merge({{(8-INST_W){1'b0}}, part_inst_q, 8'h00, part_index_q}, wb_dat_i, wb_sel_i);
   assign mon_sel_w = merge({{(8-INST_W){1'b0}}, mon_inst_q, 8'h00, mon_index_q}, wb_dat_i, wb_sel_i);

   // error decision per access
   always_comb begin
      err_code = instance_select_pkg::ERR_NONE;
      case (kind)
         instance_select_pkg::KIND_PART: begin
            if (undefined(part_inst_q)) begin
               err_code = instance_select_pkg::ERR_PART_UNDEF; // [R14]
            end else if (wb_adr_i == instance_select_pkg::OFF_COMMON_CTRL && part_inst_q != '0) begin
               err_code = instance_select_pkg::ERR_PART_NOCTRL; // [R21]
            end else if (wb_adr_i == instance_select_pkg::OFF_PART_CTRL && !HAS_PART[part_inst_q]) begin
               err_code = instance_select_pkg::ERR_PART_NOCTRL; // [R14]
            end
         end
         instance_select_pkg::KIND_MON: begin
            if (undefined(mon_inst_q)) begin
               err_code = instance_select_pkg::ERR_MON_UNDEF; // [R15]
            end else if (wb_adr_i == instance_select_pkg::OFF_GLOBAL_MON && mon_inst_q != '0) begin
               err_code = instance_select_pkg::ERR_MON_NOTYPE; // [R7]
            end else if (wb_adr_i != instance_select_pkg::OFF_GLOBAL_MON && !HAS_BW_MON[mon_inst_q]) begin
               err_code = instance_select_pkg::ERR_MON_NOTYPE; // [R15]
            end
         end
         instance_select_pkg::KIND_ID: begin
            // id reads never fail, even on an undefined instance
            if (wb_we_i) begin
               err_code = instance_select_pkg::ERR_RO_WRITE; // [R13]
            end
         end
         instance_select_pkg::KIND_FIXED: begin
            // these complete whatever instance is selected
            if (wb_we_i && (wb_adr_i == instance_select_pkg::OFF_ARCH_ID || wb_adr_i == instance_select_pkg::OFF_IMPL_ID
                  || wb_adr_i == instance_select_pkg::OFF_NARROW_ID || wb_adr_i == instance_select_pkg::OFF_SEC_ID)) begin
               err_code = instance_select_pkg::ERR_RO_WRITE; // [R23]
            end
         end
         default: begin
            err_code = instance_select_pkg::ERR_NONE; // unmapped: read zero, write dropped
         end
      endcase
   end

   assign access_ok = req && (err_code == instance_select_pkg::ERR_NONE);
   assign capture_pulse = access_ok && wb_we_i && wb_adr_i == instance_select_pkg::OFF_CAPT_EVT; // [R9]

   // id registers, all steered by the partition selector only
   always_comb begin
      logic und;
      logic [INST_W-1:0] pi;
      logic [7:0] pw; // priority and long-width slice
      logic [7:0] bw; // bandwidth slice
      und = undefined(part_inst_q); // [R8]
      pi = part_inst_q;
      pw = slice8(PRI_WIDTH, part_inst_q);
      bw = slice8(BW_WIDTH, part_inst_q);
      id_word = instance_select_pkg::ZERO_WORD;
      case (wb_adr_i)
         instance_select_pkg::OFF_MAIN_ID: begin
            id_word[instance_select_pkg::MAIN_MAX_LSB +: 4] = MAX_INDEX; // [R20]
            if (!und) begin
               id_word[instance_select_pkg::MAIN_HAS_PRI] = HAS_INT_PRI[pi] || HAS_DS_PRI[pi];
               id_word[instance_select_pkg::MAIN_HAS_BW] = HAS_PART[pi];
               id_word[instance_select_pkg::MAIN_HAS_MON] = HAS_BW_MON[pi];
            end
         end
         instance_select_pkg::OFF_PRI_ID: begin
            // global priority shows only at instance 0
            if (!und && (PRI_LOCAL || pi == '0)) begin // [R4]
               if (HAS_INT_PRI[pi]) begin
                  id_word[instance_select_pkg::PRI_HAS_INT] = 1'b1; // [R2]
                  id_word[instance_select_pkg::PRI_INT_POL] = 1'b1; // [R2]
                  id_word[instance_select_pkg::PRI_INT_WD_LSB +: 6] = pw[5:0]; // [R2]
               end
               if (HAS_DS_PRI[pi]) begin
                  id_word[instance_select_pkg::PRI_HAS_DS] = 1'b1; // [R1]
                  id_word[instance_select_pkg::PRI_DS_POL] = 1'b1; // [R1]
                  id_word[instance_select_pkg::PRI_DS_WD_LSB +: 6] = pw[5:0];
               end
            end
         end
         instance_select_pkg::OFF_BW_PART_ID: begin
            if (!und && HAS_PART[pi]) begin
               id_word[7:0] = bw; // [R3]
            end
         end
         instance_select_pkg::OFF_BW_MON_ID: begin
            if (!und && HAS_BW_MON[pi]) begin
               id_word[instance_select_pkg::SEL_INDEX_W-1:0] = 16'h0001; // one monitor per instance
               id_word[instance_select_pkg::BWM_SCALE_LSB +: 5] = bw[4:0]; // [R3]
               id_word[instance_select_pkg::BWM_LWD_LSB +: 6] = pw[5:0]; // [R3]
               id_word[instance_select_pkg::BWM_HAS_LONG] = pi[0]; // [R3]
               id_word[instance_select_pkg::BWM_HAS_RW] = 1'b0;
               id_word[instance_select_pkg::BWM_HAS_CAPT] = 1'b1; // [R12]
            end
         end
         instance_select_pkg::OFF_MON_SUM_ID: begin
            if (!und) begin
               id_word[instance_select_pkg::SUM_HAS_BWU] = HAS_BW_MON[pi]; // [R12]
               id_word[instance_select_pkg::SUM_HAS_CSU] = 1'b0;
            end
         end
         default: begin
            id_word = instance_select_pkg::ZERO_WORD; // cache monitor id: none fitted
         end
      endcase
   end

   // bus acknowledge and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= instance_select_pkg::ZERO_WORD;
      end else begin
         ack_q <= req;
         if (req && !wb_we_i) begin
            if (!access_ok) begin
               rdata_q <= instance_select_pkg::ZERO_WORD; // failed access reads zero
            end else begin
               case (wb_adr_i)
                  instance_select_pkg::OFF_ARCH_ID: rdata_q <= instance_select_pkg::ARCH_ID_VALUE; // [R5]
                  instance_select_pkg::OFF_IMPL_ID: rdata_q <= IMPL_ID_VALUE; // [R5]
                  instance_select_pkg::OFF_NARROW_ID: rdata_q <= NARROW_ID_VALUE; // [R5]
                  instance_select_pkg::OFF_SEC_ID: rdata_q <= SEC_ID_VALUE; // [R5]
                  instance_select_pkg::OFF_ERR_CTRL: rdata_q <= {31'h0000_0000, err_ctrl_q};
                  instance_select_pkg::OFF_ERR_SYND: begin
                     rdata_q <= instance_select_pkg::ZERO_WORD;
                     rdata_q[instance_select_pkg::ESR_CODE_LSB +: 4] <= esr_code_q;
                     rdata_q[instance_select_pkg::ESR_INST_LSB +: INST_W] <= esr_inst_q;
                     rdata_q[instance_select_pkg::ESR_OVERWRITE] <= esr_over_q;
                  end
                  instance_select_pkg::OFF_PART_SEL: begin
                     rdata_q <= instance_select_pkg::ZERO_WORD;
                     rdata_q[instance_select_pkg::SEL_INDEX_W-1:0] <= part_index_q;
                     rdata_q[instance_select_pkg::SEL_INST_LSB +: INST_W] <= part_inst_q; // [R11]
                  end
                  instance_select_pkg::OFF_MON_SEL: begin
                     rdata_q <= instance_select_pkg::ZERO_WORD;
                     rdata_q[instance_select_pkg::SEL_INDEX_W-1:0] <= mon_index_q;
                     rdata_q[instance_select_pkg::SEL_INST_LSB +: INST_W] <= mon_inst_q; // [R11]
                  end
                  instance_select_pkg::OFF_PART_CTRL: rdata_q <= part_ctrl_q[part_inst_q];
                  instance_select_pkg::OFF_COMMON_CTRL: rdata_q <= common_ctrl_q;
                  instance_select_pkg::OFF_MON_CFG: rdata_q <= {30'h0000_0000, mon_cfg_q[mon_inst_q]}; // [R6]
                  instance_select_pkg::OFF_MON_VAL: rdata_q <= mon_val_q[mon_inst_q]; // [R6]
                  instance_select_pkg::OFF_MON_CAPT: rdata_q <= mon_capt_q[mon_inst_q]; // [R6]
                  instance_select_pkg::OFF_GLOBAL_MON: rdata_q <= global_mon_q;
                  default: rdata_q <= id_word; // id registers, capture event and unmapped
               endcase
            end
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   // selectors; a write is seen by the very next access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         part_index_q <= '0;
         part_inst_q <= '0;
         mon_index_q <= '0;
         mon_inst_q <= '0;
      end else if (access_ok && wb_we_i) begin
         if (wb_adr_i == instance_select_pkg::OFF_PART_SEL) begin
            part_index_q <= part_sel_w[instance_select_pkg::SEL_INDEX_W-1:0]; // [R22]
            part_inst_q <= part_sel_w[instance_select_pkg::SEL_INST_LSB +: INST_W]; // [R11]
         end
         if (wb_adr_i == instance_select_pkg::OFF_MON_SEL) begin
            mon_index_q <= mon_sel_w[instance_select_pkg::SEL_INDEX_W-1:0]; // [R22]
            mon_inst_q <= mon_sel_w[instance_select_pkg::SEL_INST_LSB +: INST_W]; // [R11]
         end
      end
   end

   // error control and syndrome; hardware logging wins over software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_ctrl_q <= 1'b0;
         esr_code_q <= instance_select_pkg::ERR_NONE;
         esr_inst_q <= '0;
         esr_over_q <= 1'b0;
      end else if (req && err_code != instance_select_pkg::ERR_NONE) begin
         // second error before software cleared the first
         if (esr_code_q != instance_select_pkg::ERR_NONE) begin
            esr_over_q <= 1'b1;
         end
         esr_code_q <= err_code;
         if (kind == instance_select_pkg::KIND_PART) begin
            esr_inst_q <= part_inst_q; // [R16]
         end else if (kind == instance_select_pkg::KIND_MON) begin
            esr_inst_q <= mon_inst_q; // [R16]
         end else begin
            esr_inst_q <= '0; // [R17]
         end
      end else if (access_ok && wb_we_i) begin
         if (wb_adr_i == instance_select_pkg::OFF_ERR_CTRL && wb_sel_i[0]) begin
            err_ctrl_q <= wb_dat_i[0];
         end
         if (wb_adr_i == instance_select_pkg::OFF_ERR_SYND && wb_sel_i[3]) begin
            esr_code_q <= wb_dat_i[instance_select_pkg::ESR_CODE_LSB +: 4];
            esr_over_q <= wb_dat_i[instance_select_pkg::ESR_OVERWRITE];
         end
         if (wb_adr_i == instance_select_pkg::OFF_ERR_SYND && wb_sel_i[2]) begin
            esr_inst_q <= wb_dat_i[instance_select_pkg::ESR_INST_LSB +: INST_W];
         end
      end
   end

   // partitioning controls, per instance and shared
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_INST; i++) begin
            part_ctrl_q[i] <= instance_select_pkg::ZERO_WORD;
         end
         common_ctrl_q <= instance_select_pkg::ZERO_WORD;
      end else if (access_ok && wb_we_i) begin
         if (wb_adr_i == instance_select_pkg::OFF_PART_CTRL) begin
            part_ctrl_q[part_inst_q] <= merge(part_ctrl_q[part_inst_q], wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == instance_select_pkg::OFF_COMMON_CTRL) begin
            common_ctrl_q <= merge(common_ctrl_q, wb_dat_i, wb_sel_i); // [R21]
         end
      end
   end

   // two-flop synchroniser on the event pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_meta_q <= '0;
         evt_q <= '0;
      end else begin
         evt_meta_q <= mon_event_i;
         evt_q <= evt_meta_q;
      end
   end

   // monitors: count events, capture on event register write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_INST; i++) begin
            mon_cfg_q[i] <= 2'b00;
            mon_val_q[i] <= instance_select_pkg::ZERO_WORD;
            mon_capt_q[i] <= instance_select_pkg::ZERO_WORD;
         end
         global_mon_q <= instance_select_pkg::ZERO_WORD;
      end else begin
         for (int i = 0; i < NUM_INST; i++) begin
            // counting only where a monitor is fitted
            if (HAS_BW_MON[i] && mon_cfg_q[i][instance_select_pkg::MCFG_EN] && evt_q[i]) begin
               mon_val_q[i] <= mon_val_q[i] + 32'h0000_0001;
            end
            // capture hits every instance with capture enabled, not just the selected one
            if (capture_pulse && mon_cfg_q[i][instance_select_pkg::MCFG_CAPT_EN]) begin
               mon_capt_q[i] <= mon_val_q[i]; // [R9]
            end
         end
         // component monitor counts any event
         if (|evt_q) begin
            global_mon_q <= global_mon_q + 32'h0000_0001;
         end
         if (access_ok && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
               instance_select_pkg::OFF_MON_CFG: mon_cfg_q[mon_inst_q] <= wb_dat_i[1:0]; // [R6]
               instance_select_pkg::OFF_MON_VAL: mon_val_q[mon_inst_q] <= wb_dat_i; // [R6]
               instance_select_pkg::OFF_MON_CAPT: mon_capt_q[mon_inst_q] <= wb_dat_i; // [R6]
               instance_select_pkg::OFF_GLOBAL_MON: global_mon_q <= wb_dat_i; // [R7]
               default: begin
                  // other writes handled elsewhere
               end
            endcase
         end
      end
   end

endmodule

// File: hdl/instance_select_pkg.sv
package instance_select_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFF_MAIN_ID = 8'h00;
   localparam logic [7:0] OFF_PRI_ID = 8'h04;
   localparam logic [7:0] OFF_BW_PART_ID = 8'h08;
   localparam logic [7:0] OFF_BW_MON_ID = 8'h0c;
   localparam logic [7:0] OFF_MON_SUM_ID = 8'h10;
   localparam logic [7:0] OFF_CACHE_MON_ID = 8'h14;
   localparam logic [7:0] OFF_ARCH_ID = 8'h18;
   localparam logic [7:0] OFF_IMPL_ID = 8'h1c;
   localparam logic [7:0] OFF_NARROW_ID = 8'h20;
   localparam logic [7:0] OFF_SEC_ID = 8'h24;
   localparam logic [7:0] OFF_ERR_CTRL = 8'h28;
   localparam logic [7:0] OFF_ERR_SYND = 8'h2c;
   localparam logic [7:0] OFF_PART_SEL = 8'h30;
   localparam logic [7:0] OFF_MON_SEL = 8'h34;
   localparam logic [7:0] OFF_CAPT_EVT = 8'h38;
   localparam logic [7:0] OFF_PART_CTRL = 8'h40;
   localparam logic [7:0] OFF_COMMON_CTRL = 8'h44;
   localparam logic [7:0] OFF_MON_CFG = 8'h50;
   localparam logic [7:0] OFF_MON_VAL = 8'h54;
   localparam logic [7:0] OFF_MON_CAPT = 8'h58;
   localparam logic [7:0] OFF_GLOBAL_MON = 8'h5c;

   // selector layout: index low, instance high
   localparam int unsigned SEL_INST_LSB = 24;
   localparam int unsigned SEL_INDEX_W = 16;

   // main id layout
   localparam int unsigned MAIN_HAS_PRI = 0;
   localparam int unsigned MAIN_HAS_BW = 1;
   localparam int unsigned MAIN_HAS_MON = 2;
   localparam int unsigned MAIN_MAX_LSB = 16;

   // priority id layout
   localparam int unsigned PRI_HAS_INT = 0;
   localparam int unsigned PRI_INT_POL = 1;
   localparam int unsigned PRI_INT_WD_LSB = 4;
   localparam int unsigned PRI_HAS_DS = 16;
   localparam int unsigned PRI_DS_POL = 17;
   localparam int unsigned PRI_DS_WD_LSB = 20;

   // bandwidth usage monitor id layout
   localparam int unsigned BWM_SCALE_LSB = 16;
   localparam int unsigned BWM_LWD_LSB = 21;
   localparam int unsigned BWM_HAS_LONG = 29;
   localparam int unsigned BWM_HAS_RW = 30;
   localparam int unsigned BWM_HAS_CAPT = 31;

   // monitor summary layout
   localparam int unsigned SUM_HAS_BWU = 16;
   localparam int unsigned SUM_HAS_CSU = 17;

   // error syndrome layout
   localparam int unsigned ESR_INST_LSB = 16;
   localparam int unsigned ESR_CODE_LSB = 24;
   localparam int unsigned ESR_OVERWRITE = 31;

   // monitor config bits
   localparam int unsigned MCFG_EN = 0;
   localparam int unsigned MCFG_CAPT_EN = 1;

   // error codes
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_RO_WRITE = 4'hf;
   localparam logic [3:0] ERR_PART_UNDEF = 4'h8;
   localparam logic [3:0] ERR_PART_NOCTRL = 4'h9;
   localparam logic [3:0] ERR_MON_UNDEF = 4'ha;
   localparam logic [3:0] ERR_MON_NOTYPE = 4'hb;

   // fixed values
   localparam logic [31:0] ARCH_ID_VALUE = 32'h0000_0011;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // kind of register an address names
   typedef enum {
      KIND_ID, KIND_FIXED, KIND_PART, KIND_MON, KIND_NONE
   } reg_kind_type;

endpackage
